// *** dma_channel_status_regs.sv ***
`timescale 1ns/1ps
// Functional notes
// - Clear, set, invert aliases at 4, 8, C.
// - Flag when destination pointer reaches half size.
// - Flag block done on larger size or match.
// - Flag each completed cell of bytes.
// - Matching abort interrupt stops channel, flags.
// - Flag invalid source or destination address.

module dma_channel_status_regs
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [dma_chan_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [dma_chan_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [dma_chan_pkg::STRB_W-1:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [dma_chan_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [dma_chan_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic XFER_STB,
    input wire logic [7:0] XFER_DATA,
    input wire logic ABORT_IRQ_STB,
    input wire logic [7:0] ABORT_IRQ_NUM,
    input wire logic ADDR_ERR,
    input wire logic [dma_chan_pkg::SIZE_W-1:0] CH2_CELL_PTR,
    output logic XFER_EN,
    output logic IRQ
);
    import dma_chan_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg, irq_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg;
    logic [STRB_W-1:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [DATA_W-1:0] con_reg, econ_reg, int_en_reg, ssa_reg, dsa_reg;
    logic [SIZE_W-1:0] ssize_reg, dsize_reg, csize_reg;
    logic [SIZE_W-1:0] sptr_reg, dptr_reg, cptr_reg, blk_reg;
    logic [7:0] pdat_reg, ch2_pdat_reg;
    logic [FLAG_N-1:0] flags;
    logic [DATA_W-1:0] merged, old_word;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a[ADDR_W-1:SLOT_LSB] == off[ADDR_W-1:SLOT_LSB];
    endfunction : reg_hit

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        return reg_hit(a, OFF_CH2_CPTR) | reg_hit(a, OFF_CH2_PDAT) | reg_hit(a, OFF_CON)
             | reg_hit(a, OFF_ECON) | reg_hit(a, OFF_INT) | reg_hit(a, OFF_SSA)
             | reg_hit(a, OFF_DSA) | reg_hit(a, OFF_SSIZ) | reg_hit(a, OFF_DSIZ)
             | reg_hit(a, OFF_SPTR) | reg_hit(a, OFF_DPTR) | reg_hit(a, OFF_CSIZ)
             | reg_hit(a, OFF_CPTR) | reg_hit(a, OFF_PDAT);
    endfunction : reg_mapped

    // Every alias of a slot reads the register itself; unmapped reads zero.
    function automatic logic [DATA_W-1:0] reg_value(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        if (reg_hit(a, OFF_CH2_CPTR)) v = DATA_W'(CH2_CELL_PTR);
        if (reg_hit(a, OFF_CH2_PDAT)) v = DATA_W'(ch2_pdat_reg);
        if (reg_hit(a, OFF_CON)) v = con_reg | (DATA_W'(con_reg[CON_EN_BIT]) << CON_BUSY_BIT);
        if (reg_hit(a, OFF_ECON)) v = econ_reg;
        if (reg_hit(a, OFF_INT)) v = int_en_reg | DATA_W'(flags);
        if (reg_hit(a, OFF_SSA)) v = ssa_reg;
        if (reg_hit(a, OFF_DSA)) v = dsa_reg;
        if (reg_hit(a, OFF_SSIZ)) v = DATA_W'(ssize_reg);
        if (reg_hit(a, OFF_DSIZ)) v = DATA_W'(dsize_reg);
        if (reg_hit(a, OFF_SPTR)) v = DATA_W'(sptr_reg);
        if (reg_hit(a, OFF_DPTR)) v = DATA_W'(dptr_reg);
        if (reg_hit(a, OFF_CSIZ)) v = DATA_W'(csize_reg);
        if (reg_hit(a, OFF_CPTR)) v = DATA_W'(cptr_reg);
        if (reg_hit(a, OFF_PDAT)) v = DATA_W'(pdat_reg);
        return v;
    endfunction : reg_value

    // Only the writable bits of a register take the merged value.
    function automatic logic [DATA_W-1:0] apply(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wm);
        return (old & ~wm) | (merged & wm);
    endfunction : apply

    // ----------------------------------------------------------------
    // AXI4-Lite handshakes
    // ----------------------------------------------------------------
    wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire [1:0] wr_op = awaddr_reg[SLOT_LSB-1:ALIAS_LSB];
    wire rd_take = S_AXI_ARVALID & S_AXI_ARREADY;

    assign S_AXI_AWREADY = CE & ~aw_held_reg;
    assign S_AXI_WREADY = CE & ~w_held_reg;
    assign S_AXI_ARREADY = CE & ~rvalid_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

    // Address and data are caught independently, in either order.
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end
        else if (CE)
        begin
            if (S_AXI_AWVALID & S_AXI_AWREADY)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= S_AXI_AWADDR;
            end
            else if (do_write)
                aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end
        else if (CE)
        begin
            if (S_AXI_WVALID & S_AXI_WREADY)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            else if (do_write)
                w_held_reg <= 1'b0;
        end
    end

    // Write response; a held write waits while a response is unread.
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else if (CE)
        begin
            if (do_write)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= reg_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (S_AXI_BREADY)
                bvalid_reg <= 1'b0;
        end
    end

    // Read data is registered, so a read answers one cycle after it is taken.
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else if (CE)
        begin
            if (rd_take)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg <= reg_value(S_AXI_ARADDR);
                rresp_reg <= reg_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (S_AXI_RREADY)
                rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Alias merge of the write
    // ----------------------------------------------------------------
    // A process, not a port expression, so the old word follows every register that the decode reads.
    always_comb old_word = reg_value(awaddr_reg);

    dma_alias_merge u_merge
    (
        .old_val(old_word),
        .wdata(wdata_reg),
        .wstrb(wstrb_reg),
        .op(wr_op),
        .new_val(merged)
    );

    wire wr_con = do_write & reg_hit(awaddr_reg, OFF_CON);
    wire wr_econ = do_write & reg_hit(awaddr_reg, OFF_ECON);
    wire wr_int = do_write & reg_hit(awaddr_reg, OFF_INT);

    // ----------------------------------------------------------------
    // Transfer progress and events
    // ----------------------------------------------------------------
    wire chan_en = con_reg[CON_EN_BIT];
    wire byte_go = XFER_STB & chan_en;
    wire [SIZE_W-1:0] sptr_inc = SIZE_W'(sptr_reg + 1'b1);
    wire [SIZE_W-1:0] dptr_inc = SIZE_W'(dptr_reg + 1'b1);
    wire [SIZE_W-1:0] cptr_inc = SIZE_W'(cptr_reg + 1'b1);
    wire [SIZE_W-1:0] blk_inc = SIZE_W'(blk_reg + 1'b1);
    wire [SIZE_W-1:0] blk_max = (ssize_reg >= dsize_reg) ? ssize_reg : dsize_reg;
    wire src_wrap = byte_go & (sptr_inc == ssize_reg);
    wire src_half = byte_go & (ssize_reg != '0) & (sptr_inc == (ssize_reg >> 1));
    wire dst_wrap = byte_go & (dptr_inc == dsize_reg);
    wire dst_half = byte_go & (dsize_reg != '0) & (dptr_inc == (dsize_reg >> 1));
    wire cell_hit = byte_go & (cptr_inc == csize_reg);
    wire pat_hit = byte_go & econ_reg[ECON_PAT_EN_BIT] & (XFER_DATA == pdat_reg);
    wire block_done = (byte_go & (blk_inc == blk_max)) | pat_hit;
    wire abort_hit = ABORT_IRQ_STB & chan_en & econ_reg[ECON_ABORT_EN_BIT]
                   & (ABORT_IRQ_NUM == econ_reg[AIRQ_MSB:AIRQ_LSB]);
    // An ended block keeps the channel armed only in auto-enable mode.
    wire restart = block_done | abort_hit | ADDR_ERR;
    wire stop = abort_hit | ADDR_ERR | (block_done & ~con_reg[CON_AUTO_BIT]);

    wire [FLAG_N-1:0] events;
    assign events[F_ADDR_ERR] = ADDR_ERR;
    assign events[F_ABORT] = abort_hit;
    assign events[F_CELL] = cell_hit;
    assign events[F_BLOCK] = block_done;
    assign events[F_DHALF] = dst_half;
    assign events[F_DDONE] = dst_wrap;
    assign events[F_SHALF] = src_half;
    assign events[F_SDONE] = src_wrap;

    // Software lowers a flag by any write whose merged value drops it.
    wire [FLAG_N-1:0] flag_clr = wr_int ? (flags & ~merged[FLAG_N-1:0]) : '0;

    dma_flag_bank #(.N(FLAG_N)) u_flags
    (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .set_ev(events),
        .clr_req(flag_clr),
        .flags(flags)
    );

    // Pointers restart at a wrap or when the block ends or is stopped.
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            sptr_reg <= '0;
            dptr_reg <= '0;
            cptr_reg <= '0;
            blk_reg <= '0;
        end
        else if (CE)
        begin
            sptr_reg <= (restart | src_wrap) ? '0 : (byte_go ? sptr_inc : sptr_reg);
            dptr_reg <= (restart | dst_wrap) ? '0 : (byte_go ? dptr_inc : dptr_reg);
            cptr_reg <= (restart | cell_hit) ? '0 : (byte_go ? cptr_inc : cptr_reg);
            blk_reg <= restart ? '0 : (byte_go ? blk_inc : blk_reg);
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // merged value stored
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            con_reg <= '0;
            econ_reg <= ECON_RST;
            int_en_reg <= '0;
            ssa_reg <= '0;
            dsa_reg <= '0;
            ssize_reg <= '0;
            dsize_reg <= '0;
            csize_reg <= '0;
            pdat_reg <= '0;
            ch2_pdat_reg <= '0;
        end
        else if (CE)
        begin
            // hardware stop wins over software enable.
            con_reg <= (wr_con ? apply(con_reg, CON_WMASK) : con_reg) & ~(DATA_W'(stop) << CON_EN_BIT);
            if (wr_econ) econ_reg <= apply(econ_reg, ECON_WMASK);
            if (wr_int) int_en_reg <= apply(int_en_reg, INT_EN_MASK);
            if (do_write & reg_hit(awaddr_reg, OFF_SSA)) ssa_reg <= apply(ssa_reg, FULL_MASK);
            if (do_write & reg_hit(awaddr_reg, OFF_DSA)) dsa_reg <= apply(dsa_reg, FULL_MASK);
            if (do_write & reg_hit(awaddr_reg, OFF_SSIZ)) ssize_reg <= SIZE_W'(merged & SIZE_MASK);
            if (do_write & reg_hit(awaddr_reg, OFF_DSIZ)) dsize_reg <= SIZE_W'(merged & SIZE_MASK);
            if (do_write & reg_hit(awaddr_reg, OFF_CSIZ)) csize_reg <= SIZE_W'(merged & SIZE_MASK);
            if (do_write & reg_hit(awaddr_reg, OFF_PDAT)) pdat_reg <= 8'(merged & PDAT_MASK);
            if (do_write & reg_hit(awaddr_reg, OFF_CH2_PDAT)) ch2_pdat_reg <= 8'(merged & PDAT_MASK);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // masked flags to interrupt
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
            irq_reg <= 1'b0;
        else if (CE)
            irq_reg <= |(flags & int_en_reg[INT_EN_LSB +: FLAG_N]);
    end

    assign IRQ = irq_reg;
    assign XFER_EN = chan_en;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    a_alias_set_size: assert property (CE && do_write && reg_hit(awaddr_reg, OFF_SSIZ)
        && wr_op == OP_SET && wstrb_reg == 4'hF
        |=> ssize_reg == ($past(ssize_reg) | $past(wdata_reg[SIZE_W-1:0])))
        else $error("set alias did not OR into source size");

    a_alias_clr_size: assert property (CE && do_write && reg_hit(awaddr_reg, OFF_CSIZ)
        && wr_op == OP_CLR && wstrb_reg == 4'hF
        |=> csize_reg == ($past(csize_reg) & ~$past(wdata_reg[SIZE_W-1:0])))
        else $error("clear alias did not clear cell size bits");

    a_half_full_flag: assert property (CE && dst_half |=> flags[F_DHALF])
        else $error("half-full point did not raise its flag");

    a_block_done_stop: assert property (CE && block_done && !con_reg[CON_AUTO_BIT]
        |=> flags[F_BLOCK] && !chan_en && blk_reg == '0)
        else $error("block end did not flag and stop the channel");

    a_cell_done_flag: assert property (CE && cell_hit |=> flags[F_CELL] && cptr_reg == '0)
        else $error("cell end did not flag and restart the cell count");

    a_abort_stops: assert property (CE && abort_hit |=> flags[F_ABORT] && !XFER_EN)
        else $error("matching abort request did not stop the channel");

    a_addr_error: assert property (CE && ADDR_ERR |=> flags[F_ADDR_ERR] && !XFER_EN)
        else $error("address error did not flag and stop");

    a_irq_follows: assert property (CE && ADDR_ERR && int_en_reg[INT_EN_LSB + F_ADDR_ERR]
        ##1 CE |=> IRQ)
        else $error("enabled flag did not raise the interrupt");

    a_write_answer: assert property (CE && do_write |=> S_AXI_BVALID)
        else $error("held write got no response");

    c_block_done: cover property (CE && block_done);
    c_abort: cover property (CE && abort_hit);
    c_set_clear_race: cover property (CE && wr_int && |(events & flag_clr));

endmodule : dma_channel_status_regs

// *** dma_chan_pkg.sv ***
package dma_chan_pkg;

    // ----------------------------------------------------------------
    // Bus and address layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int ALIAS_LSB = 2;
    localparam int SLOT_LSB = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Alias operations selected by address bits 3:2.
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CLR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INV = 2'h3;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CH2_CPTR = 14'h3280;
    localparam logic [ADDR_W-1:0] OFF_CH2_PDAT = 14'h3290;
    localparam logic [ADDR_W-1:0] OFF_CON = 14'h32A0;
    localparam logic [ADDR_W-1:0] OFF_ECON = 14'h32B0;
    localparam logic [ADDR_W-1:0] OFF_INT = 14'h32C0;
    localparam logic [ADDR_W-1:0] OFF_SSA = 14'h32D0;
    localparam logic [ADDR_W-1:0] OFF_DSA = 14'h32E0;
    localparam logic [ADDR_W-1:0] OFF_SSIZ = 14'h32F0;
    localparam logic [ADDR_W-1:0] OFF_DSIZ = 14'h3300;
    localparam logic [ADDR_W-1:0] OFF_SPTR = 14'h3310;
    localparam logic [ADDR_W-1:0] OFF_DPTR = 14'h3320;
    localparam logic [ADDR_W-1:0] OFF_CSIZ = 14'h3330;
    localparam logic [ADDR_W-1:0] OFF_CPTR = 14'h3340;
    localparam logic [ADDR_W-1:0] OFF_PDAT = 14'h3350;

    // ----------------------------------------------------------------
    // Fields, masks and reset values
    // ----------------------------------------------------------------
    localparam int SIZE_W = 16;
    localparam int FLAG_N = 8;
    localparam int CON_EN_BIT = 7;
    localparam int CON_AUTO_BIT = 4;
    localparam int CON_BUSY_BIT = 15;
    localparam int ECON_ABORT_EN_BIT = 3;
    localparam int ECON_PAT_EN_BIT = 5;
    localparam int AIRQ_LSB = 16;
    localparam int AIRQ_MSB = 23;
    localparam int INT_EN_LSB = 16;
    localparam logic [DATA_W-1:0] CON_WMASK = 32'h000001F3;
    localparam logic [DATA_W-1:0] ECON_WMASK = 32'h00FFFFF8;
    localparam logic [DATA_W-1:0] ECON_RST = 32'h00FFFFF8;
    localparam logic [DATA_W-1:0] INT_EN_MASK = 32'h00FF0000;
    localparam logic [DATA_W-1:0] SIZE_MASK = 32'h0000FFFF;
    localparam logic [DATA_W-1:0] PDAT_MASK = 32'h000000FF;
    localparam logic [DATA_W-1:0] FULL_MASK = 32'hFFFFFFFF;

    // Flag positions in the interrupt register.
    localparam int F_ADDR_ERR = 0;
    localparam int F_ABORT = 1;
    localparam int F_CELL = 2;
    localparam int F_BLOCK = 3;
    localparam int F_DHALF = 4;
    localparam int F_DDONE = 5;
    localparam int F_SHALF = 6;
    localparam int F_SDONE = 7;

endpackage : dma_chan_pkg

// *** dma_alias_merge.sv ***
`timescale 1ns/1ps

module dma_alias_merge
(
    input wire logic [dma_chan_pkg::DATA_W-1:0] old_val,
    input wire logic [dma_chan_pkg::DATA_W-1:0] wdata,
    input wire logic [dma_chan_pkg::STRB_W-1:0] wstrb,
    input wire logic [1:0] op,
    output logic [dma_chan_pkg::DATA_W-1:0] new_val
);
    import dma_chan_pkg::*;

    logic [DATA_W-1:0] lane_mask;
    logic [DATA_W-1:0] bits;

    // Byte lanes not strobed never change, whatever the alias.
    genvar g;
    generate
        for (g = 0; g < STRB_W; g++)
        begin : g_lane
            assign lane_mask[g*8 +: 8] = {8{wstrb[g]}};
        end
    endgenerate

    assign bits = wdata & lane_mask;

    // Plain store, then clear, set and invert of the bits written as one.
    assign new_val = (op == OP_CLR) ? (old_val & ~bits) :
                     (op == OP_SET) ? (old_val | bits) :
                     (op == OP_INV) ? (old_val ^ bits) :
                     ((old_val & ~lane_mask) | bits);

endmodule : dma_alias_merge

// *** dma_flag_bank.sv ***
`timescale 1ns/1ps

module dma_flag_bank
#(
    parameter int N = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [N-1:0] set_ev,
    input wire logic [N-1:0] clr_req,
    output logic [N-1:0] flags
);
    // ----------------------------------------------------------------
    // Sticky flags
    // ----------------------------------------------------------------
    // An event in the same cycle as a software clear keeps the flag set,
    // so no event is ever lost to a racing clear.
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_flag
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    flags[g] <= 1'b0;
                else if (ce)
                    flags[g] <= set_ev[g] | (flags[g] & ~clr_req[g]);
            end
        end
    endgenerate

endmodule : dma_flag_bank

// *** dma_far_side.sv ***
`timescale 1ns/1ps

module dma_far_side
(
    input wire logic clk,
    input wire logic xfer_en,
    input wire logic start,
    input wire logic [7:0] nbytes,
    output logic busy,
    output logic xfer_stb,
    output logic [7:0] xfer_data
);
    logic [7:0] left_reg = 8'h00;
    logic tick_reg = 1'b0;

    // Load a byte count, then move one byte a cycle while the channel allows it.
    always_ff @(posedge clk)
    begin
        tick_reg <= ~tick_reg;
        if (start)
            left_reg <= nbytes;
        else if (xfer_stb)
            left_reg <= left_reg - 8'h01;
    end

    // Idle data toggles every cycle, so a stale byte never looks valid.
    assign busy = left_reg != 8'h00;
    assign xfer_stb = busy & xfer_en;
    assign xfer_data = xfer_stb ? left_reg : {8{tick_reg}};
endmodule : dma_far_side

// *** dma_channel_status_regs_bench.sv ***
`timescale 1ns/1ps

module dma_channel_status_regs_bench;
    import dma_chan_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [13:0] awa = 14'h0000, ara = 14'h0000;
    logic [31:0] wd = 32'h00000000, rd;
    logic abs = 1'b0, aer = 1'b0, go = 1'b0;
    logic [7:0] anum = 8'h00, nb = 8'h00;
    wire awr, wr, bv, arr, rv, xs, xen, irq, busy;
    wire [1:0] br, rrs;
    wire [7:0] xd;
    wire [31:0] rdat;
    logic [1:0] rr;
    int mismatches = 0, checked = 0;

    dma_channel_status_regs dut (.CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_BRESP(br),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rrs),
        .XFER_STB(xs), .XFER_DATA(xd), .ABORT_IRQ_STB(abs), .ABORT_IRQ_NUM(anum),
        .ADDR_ERR(aer), .CH2_CELL_PTR(16'h1234), .XFER_EN(xen), .IRQ(irq));
    dma_far_side far (.clk(clk), .xfer_en(xen), .start(go), .nbytes(nb),
        .busy(busy), .xfer_stb(xs), .xfer_data(xd));

    // Free-running 40 MHz clock.
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Bus and check helpers
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic lost();
        mismatches++;
        print_verdict();
    endtask : lost

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Handshakes are judged on values sampled half a cycle before each edge.
    task automatic wr_reg(input logic [13:0] a, input logic [31:0] d);
        int n;
        bit aw, w, b;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk);
            aw = awv && awr;
            w = wv && wr;
            b = bv === 1'b1;
            @(posedge clk);
            if (aw)
                awv <= 1'b0;
            if (w)
                wv <= 1'b0;
            if (b)
                break;
        end
        bre <= 1'b0;
        if (n == 50)
            lost();
    endtask : wr_reg

    task automatic rd_reg(input string nm, input logic [13:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
        bit ar, r;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge clk);
            ar = arv && arr;
            r = rv === 1'b1;
            rd = rdat;
            rr = rrs;
            @(posedge clk);
            if (ar)
                arv <= 1'b0;
            if (r)
                break;
        end
        rre <= 1'b0;
        if (n == 50)
            lost();
        check(nm, rd & m, e);
    endtask : rd_reg

    task automatic move(input logic [7:0] n);
        int k;
        @(posedge clk);
        go <= 1'b1;
        nb <= n;
        @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 40; k++)
        begin
            @(negedge clk);
            if (busy !== 1'b1)
                break;
        end
        if (k == 40)
            lost();
        repeat (3) @(negedge clk);
    endtask : move

    task automatic event_in(input logic a, input logic e, input logic [7:0] n);
        @(posedge clk);
        abs <= a;
        aer <= e;
        anum <= n;
        @(posedge clk);
        abs <= 1'b0;
        aer <= 1'b0;
        anum <= ~n;
        repeat (3) @(negedge clk);
    endtask : event_in

    // Reset values, a plain read-only pointer and an unmapped slot.
    task automatic t_reset();
        rd_reg("econ", OFF_ECON, FULL_MASK, 32'h00FFFFF8);
        rd_reg("int", OFF_INT, FULL_MASK, 32'h00000000);
        rd_reg("cptr2", OFF_CH2_CPTR, FULL_MASK, 32'h00001234);
        rd_reg("hole", 14'h3360, FULL_MASK, 32'h00000000);
        check("hole resp", rr, RESP_SLVERR);
        $display("reset test done");
    endtask : t_reset

    // Clear, set and invert aliases change only the bits written as one.
    task automatic t_alias();
        wr_reg(OFF_SSA, 32'h12345678);
        wr_reg(OFF_SSA + 14'h0004, 32'h0000FF00);
        rd_reg("clr", OFF_SSA, FULL_MASK, 32'h12340078);
        wr_reg(OFF_SSA + 14'h0008, 32'h0000000F);
        rd_reg("set", OFF_SSA, FULL_MASK, 32'h1234007F);
        wr_reg(OFF_SSA + 14'h000C, 32'hFFFF0000);
        rd_reg("inv", OFF_SSA + 14'h000C, FULL_MASK, 32'hEDCB007F);
        $display("alias test done");
    endtask : t_alias

    // Cells of two, half of an eight-byte destination, then the block end.
    task automatic t_xfer();
        wr_reg(OFF_DSIZ, 32'h00000008);
        wr_reg(OFF_SSIZ + 14'h0008, 32'h00000004);
        wr_reg(OFF_CSIZ, 32'h00000003);
        wr_reg(OFF_CSIZ + 14'h0004, 32'h00000001);
        wr_reg(OFF_PDAT, 32'h000000AA);
        wr_reg(OFF_INT, INT_EN_MASK);
        wr_reg(OFF_CON, 32'h00000080);
        move(8'h04);
        rd_reg("dptr", OFF_DPTR, FULL_MASK, 32'h00000004);
        rd_reg("half cell", OFF_INT, 32'h0000001C, 32'h00000014);
        check("irq", irq, 1'b1);
        move(8'h04);
        rd_reg("block", OFF_INT, 32'h0000000C, 32'h0000000C);
        wr_reg(OFF_INT, INT_EN_MASK);
        wr_reg(OFF_PDAT, 32'h00000001);
        wr_reg(OFF_CON, 32'h00000080);
        move(8'h03);
        rd_reg("match", OFF_INT, 32'h00000008, 32'h00000008);
        check("match stop", xen, 1'b0);
        $display("transfer test done");
    endtask : t_xfer

    // Only the selected interrupt number aborts the channel.
    task automatic t_abort();
        wr_reg(OFF_ECON, 32'h002A0008);
        wr_reg(OFF_CON, 32'h00000080);
        event_in(1'b1, 1'b0, 8'h15);
        rd_reg("no abort", OFF_INT, 32'h00000002, 32'h00000000);
        check("still on", xen, 1'b1);
        event_in(1'b1, 1'b0, 8'h2A);
        rd_reg("abort", OFF_INT, 32'h00000002, 32'h00000002);
        check("stopped", xen, 1'b0);
        wr_reg(OFF_INT + 14'h0004, 32'h00000002);
        $display("abort test done");
    endtask : t_abort

    // Address error raises its flag; the mask gates the interrupt output.
    task automatic t_irq();
        wr_reg(OFF_INT, 32'h00000000);
        event_in(1'b0, 1'b1, 8'h00);
        rd_reg("addr err", OFF_INT, FULL_MASK, 32'h00000001);
        check("masked", irq, 1'b0);
        wr_reg(OFF_INT + 14'h0008, 32'h00010000);
        repeat (2) @(negedge clk);
        check("unmasked", irq, 1'b1);
        event_in(1'b0, 1'b1, 8'h00);
        wr_reg(OFF_INT + 14'h0004, 32'h00000001);
        repeat (2) @(negedge clk);
        check("cleared", irq, 1'b0);
        $display("interrupt test done");
    endtask : t_irq

    // Reset is held for sixteen cycles, then the scenarios run in turn.
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_alias();
        t_xfer();
        t_abort();
        t_irq();
        print_verdict();
    end
endmodule : dma_channel_status_regs_bench
